/* temp_monitor_pkg.sv */
package temp_monitor_pkg;

	// ****************************************
	// register pointers
	// ****************************************
	localparam logic [7:0] PTR_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] PTR_REMOTE_HI = 8'h01;
	localparam logic [7:0] PTR_STATUS = 8'h02;
	localparam logic [7:0] PTR_CONFIG = 8'h03;
	localparam logic [7:0] PTR_RATE = 8'h04;
	localparam logic [7:0] PTR_LOCAL_HIGH_LIM = 8'h05;
	localparam logic [7:0] PTR_LOCAL_LOW_LIM = 8'h06;
	localparam logic [7:0] PTR_REMOTE_HIGH_LIM_HI = 8'h07;
	localparam logic [7:0] PTR_REMOTE_LOW_LIM_HI = 8'h08;
	localparam logic [7:0] PTR_REMOTE_LO = 8'h10;
	localparam logic [7:0] PTR_OFFSET_HI = 8'h11;
	localparam logic [7:0] PTR_OFFSET_LO = 8'h12;
	localparam logic [7:0] PTR_REMOTE_HIGH_LIM_LO = 8'h13;
	localparam logic [7:0] PTR_REMOTE_LOW_LIM_LO = 8'h14;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STANDBY_BIT = 6;
	localparam int ST_LOCAL_HIGH_BIT = 6;
	localparam int ST_LOCAL_LOW_BIT = 5;
	localparam int ST_REMOTE_HIGH_BIT = 4;
	localparam int ST_REMOTE_LOW_BIT = 3;
	localparam int FLG_LOCAL_HIGH = 0;
	localparam int FLG_LOCAL_LOW = 1;
	localparam int FLG_REMOTE_HIGH = 2;
	localparam int FLG_REMOTE_LOW = 3;
	localparam int LOW_FRAC_MSB = 7;
	localparam int LOW_FRAC_LSB = 5;
	localparam logic [7:0] TEMP_RESET_HI = 8'h80;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] HIGH_LIM_RESET = 8'h7f;
	localparam logic [7:0] LOW_LIM_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h07;
	localparam logic [2:0] RATE_MAX = 3'h7;
	localparam logic [10:0] REMOTE_SAT_MAX = 11'h3ff;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int RATE_UNIT_US = 1000;
	localparam int RATE_UNIT_CYCLES = (CLK_HZ / 1_000_000) * RATE_UNIT_US;
	localparam logic [1:0] BOOT_CYCLES = 2'h3;
	// bus address value is arbitrary; address pins are not modelled
	localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h4c;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SQ_BOOT,
		SQ_START,
		SQ_BUSY,
		SQ_STORE,
		SQ_WAIT
	} seq_state_e;

	typedef enum logic [2:0] {
		SB_IDLE,
		SB_ADDR,
		SB_ACK_ADDR,
		SB_WRITE,
		SB_ACK_WRITE,
		SB_READ,
		SB_ACK_READ
	} smb_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} smb_req_s;

endpackage : temp_monitor_pkg

/* sample_averager.sv */
`timescale 1ns/1ps
module sample_averager
	import temp_monitor_pkg::*;
#(
	parameter int W = 11,
	parameter int N_LOG2 = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic valid_i,
	input wire logic [W-1:0] data_i,
	output logic last_o,
	output logic done_o,
	output logic [W-1:0] avg_o
);
	logic [W+N_LOG2-1:0] sum_q;
	logic [N_LOG2-1:0] cnt_q;
	logic [W+N_LOG2-1:0] sum_next;

	assign sum_next = sum_q + {{N_LOG2{1'b0}}, data_i};
	assign last_o = &cnt_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sum_q <= '0;
			cnt_q <= '0;
			done_o <= 1'b0;
			avg_o <= '0;
		end else begin
			done_o <= valid_i & last_o;
			if (valid_i) begin
				cnt_q <= cnt_q + 1'b1;
				sum_q <= last_o ? '0 : sum_next;
				if (last_o) begin
					avg_o <= sum_next[W+N_LOG2-1:N_LOG2];
				end
			end
		end
	end

endmodule : sample_averager

/* smbus_target.sv */
`timescale 1ns/1ps
module smbus_target
	import temp_monitor_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = SMB_ADDR_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [7:0] rdata_i,
	output smb_req_s req_o,
	output logic sda_oe_o
);
	smb_state_e state_q;
	logic scl_p_q;
	logic sda_p_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic first_q;
	logic rw_q;
	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;
	logic byte_c;

	assign start_c = scl_i & scl_p_q & sda_p_q & ~sda_i;
	assign stop_c = scl_i & scl_p_q & ~sda_p_q & sda_i;
	assign rise_c = scl_i & ~scl_p_q;
	assign fall_c = ~scl_i & scl_p_q;
	assign byte_c = cnt_q == 4'h8;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= SB_IDLE;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			cnt_q <= '0;
			shift_q <= '0;
			tx_q <= '0;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			sda_oe_o <= 1'b0;
			req_o <= '0;
		end else begin
			scl_p_q <= scl_i;
			sda_p_q <= sda_i;
			req_o.wr <= 1'b0;
			req_o.rd <= 1'b0;
			if (start_c) begin
				state_q <= SB_ADDR;
				cnt_q <= '0;
				first_q <= 1'b1;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				state_q <= SB_IDLE;
				sda_oe_o <= 1'b0;
			end else if (rise_c) begin
				if (state_q == SB_ADDR || state_q == SB_WRITE || state_q == SB_READ) begin
					shift_q <= {shift_q[6:0], sda_i};
					cnt_q <= cnt_q + 1'b1;
				end
				// a nack from the host ends the read burst
				if (state_q == SB_ACK_READ && sda_i) begin
					state_q <= SB_IDLE;
				end
			end else if (fall_c) begin
				case (state_q)
					SB_ADDR: begin
						if (byte_c) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								sda_oe_o <= 1'b1;
								rw_q <= shift_q[0];
								state_q <= SB_ACK_ADDR;
							end else begin
								state_q <= SB_IDLE;
							end
						end
					end
					SB_ACK_WRITE: begin
						sda_oe_o <= 1'b0;
						cnt_q <= '0;
						state_q <= SB_WRITE;
					end
					SB_WRITE: begin
						if (byte_c) begin
							sda_oe_o <= 1'b1;
							first_q <= 1'b0;
							state_q <= SB_ACK_WRITE;
							if (first_q) begin
								req_o.ptr <= shift_q;
							end else begin
								req_o.wr <= 1'b1;
								req_o.wdata <= shift_q;
							end
						end
					end
					SB_ACK_ADDR, SB_ACK_READ: begin
						cnt_q <= '0;
						if (rw_q) begin
							sda_oe_o <= ~rdata_i[7];
							tx_q <= {rdata_i[6:0], 1'b0};
							req_o.rd <= 1'b1;
							state_q <= SB_READ;
						end else begin
							sda_oe_o <= 1'b0;
							state_q <= SB_WRITE;
						end
					end
					SB_READ: begin
						if (byte_c) begin
							sda_oe_o <= 1'b0;
							state_q <= SB_ACK_READ;
						end else begin
							sda_oe_o <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule : smbus_target

/* dual_temp_monitor_core.sv */
`timescale 1ns/1ps
// Contract
// R1 - converter runs freely, alternating local and remote channels into their registers
// R2 - local result keeps only its upper eight bits as one byte
// R3 - remote result is 11 bits: high byte at 0x01, three bits left-justified at 0x10
// R4 - 11-bit signed offset from 0x11/0x12 is added to each remote result
// R5 - both offset bytes reset to zero
// R6 - each result compared with local and remote high and low limits
// R7 - each violation sets its own flag; alert pulled low while any flag set
// R8 - host reads every register and writes writable ones over the serial bus
// R9 - control picks standby, alert mask and conversion rate
// R10 - both temperature registers reset to minus 128 degrees
// R11 - normal power-up converts and stores before the first comparison
// R12 - standby power-up compares defaults, setting both low flags
// R13 - host may lower low limits then read status to release alert
// R14 - host may leave standby then read status to release alert
// R15 - standby pin high means normal, low means standby
// R16 - converter lsb is one eighth degree, range 0 to 127.875
// R17 - each stored result averages 16 measurement cycles
// R18 - flags hold until a status read; read clears only healed flags
// R19 - alert mask keeps the alert released whatever the flags
module dual_temp_monitor_core
	import temp_monitor_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = SMB_ADDR_DEFAULT,
	parameter int RATE_UNIT = RATE_UNIT_CYCLES,
	parameter int ADC_W = 11,
	parameter int AVG_LOG2 = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic standby_select_n_i,
	input wire logic [ADC_W-1:0] adc_data_i,
	input wire logic adc_valid_i,
	output logic adc_start_o,
	output logic adc_remote_sel_o,
	output logic alert_o,
	output logic alert_oe_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] pin_raw;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic scl_s;
	logic sda_s;
	logic standby_pin_s;

	assign pin_raw = {standby_select_n_i, sda_i, scl_i};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					sync1_q[gi] <= 1'b1;
					sync2_q[gi] <= 1'b1;
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate
	assign scl_s = sync2_q[0];
	assign sda_s = sync2_q[1];
	// R15 pin polarity
	assign standby_pin_s = ~sync2_q[2];

	// ****************************************
	// serial bus target
	// ****************************************
	smb_req_s req;
	logic [7:0] rdata;
	logic sda_oe_w;

	// R8 serial register access
	smbus_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_smb (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.scl_i(scl_s),
		.sda_i(sda_s),
		.rdata_i(rdata),
		.req_o(req),
		.sda_oe_o(sda_oe_w)
	);
	assign sda_oe_o = sda_oe_w;
	// open-drain: only ever drives low
	assign sda_o = 1'b0;
	assign alert_o = 1'b0;

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] local_temp_q;
	logic [10:0] remote_temp_q;
	logic [7:0] config_q;
	logic [7:0] rate_q;
	logic [7:0] local_high_lim_q;
	logic [7:0] local_low_lim_q;
	logic [7:0] remote_high_hi_q;
	logic [7:0] remote_high_lo_q;
	logic [7:0] remote_low_hi_q;
	logic [7:0] remote_low_lo_q;
	logic [7:0] offset_hi_q;
	logic [7:0] offset_lo_q;
	logic [3:0] flags_q;
	logic [7:0] status_byte;
	logic [7:0] remote_lo_byte;

	assign remote_lo_byte = {remote_temp_q[2:0], 5'h00};
	assign status_byte = {1'b0, flags_q[FLG_LOCAL_HIGH], flags_q[FLG_LOCAL_LOW],
		flags_q[FLG_REMOTE_HIGH], flags_q[FLG_REMOTE_LOW], 3'h0};
	assign rdata = (req.ptr == PTR_LOCAL_TEMP) ? local_temp_q :
		(req.ptr == PTR_REMOTE_HI) ? remote_temp_q[10:3] :
		(req.ptr == PTR_STATUS) ? status_byte :
		(req.ptr == PTR_CONFIG) ? config_q :
		(req.ptr == PTR_RATE) ? rate_q :
		(req.ptr == PTR_LOCAL_HIGH_LIM) ? local_high_lim_q :
		(req.ptr == PTR_LOCAL_LOW_LIM) ? local_low_lim_q :
		(req.ptr == PTR_REMOTE_HIGH_LIM_HI) ? remote_high_hi_q :
		(req.ptr == PTR_REMOTE_LOW_LIM_HI) ? remote_low_hi_q :
		(req.ptr == PTR_REMOTE_LO) ? remote_lo_byte :
		(req.ptr == PTR_OFFSET_HI) ? offset_hi_q :
		(req.ptr == PTR_OFFSET_LO) ? offset_lo_q :
		(req.ptr == PTR_REMOTE_HIGH_LIM_LO) ? remote_high_lo_q :
		(req.ptr == PTR_REMOTE_LOW_LIM_LO) ? remote_low_lo_q : ZERO_BYTE;

	// R9 control writes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			config_q <= ZERO_BYTE;
			rate_q <= RATE_RESET;
			local_high_lim_q <= HIGH_LIM_RESET;
			local_low_lim_q <= LOW_LIM_RESET;
			remote_high_hi_q <= HIGH_LIM_RESET;
			remote_high_lo_q <= ZERO_BYTE;
			remote_low_hi_q <= LOW_LIM_RESET;
			remote_low_lo_q <= ZERO_BYTE;
			// R5 offset reset zero
			offset_hi_q <= ZERO_BYTE;
			offset_lo_q <= ZERO_BYTE;
		end else if (req.wr) begin
			case (req.ptr)
				PTR_CONFIG: config_q <= req.wdata;
				PTR_RATE: rate_q <= req.wdata;
				PTR_LOCAL_HIGH_LIM: local_high_lim_q <= req.wdata;
				PTR_LOCAL_LOW_LIM: local_low_lim_q <= req.wdata;
				PTR_REMOTE_HIGH_LIM_HI: remote_high_hi_q <= req.wdata;
				PTR_REMOTE_HIGH_LIM_LO: remote_high_lo_q <= req.wdata;
				PTR_REMOTE_LOW_LIM_HI: remote_low_hi_q <= req.wdata;
				PTR_REMOTE_LOW_LIM_LO: remote_low_lo_q <= req.wdata;
				PTR_OFFSET_HI: offset_hi_q <= req.wdata;
				PTR_OFFSET_LO: offset_lo_q <= req.wdata;
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	seq_state_e state_q;
	logic [23:0] wait_q;
	logic [1:0] boot_q;
	logic standby;
	logic [23:0] wait_len;
	logic avg_last;
	logic avg_done;
	logic [ADC_W-1:0] avg_val;
	logic cmp_local_q;
	logic cmp_remote_q;

	// R9 standby from pin or control bit
	assign standby = standby_pin_s | config_q[CFG_STANDBY_BIT];
	// higher rate code gives a shorter gap between conversion pairs
	assign wait_len = 24'(RATE_UNIT) << (RATE_MAX - rate_q[2:0]);

	// R17 sixteen-sample averaging
	sample_averager #(
		.W(ADC_W),
		.N_LOG2(AVG_LOG2)
	) u_avg (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.valid_i(adc_valid_i & (state_q == SQ_BUSY)),
		.data_i(adc_data_i),
		.last_o(avg_last),
		.done_o(avg_done),
		.avg_o(avg_val)
	);

	// R4 signed offset on remote
	logic signed [11:0] remote_sum;
	logic [10:0] offset_val;
	logic [10:0] remote_adj;
	assign offset_val = {offset_hi_q, offset_lo_q[LOW_FRAC_MSB:LOW_FRAC_LSB]};
	// R16 raw code is unsigned eighths, so top bit is zero
	assign remote_sum = $signed({1'b0, avg_val}) + $signed({offset_val[10], offset_val});
	// saturate rather than wrap a large positive offset into a negative reading
	assign remote_adj = (remote_sum[11:10] == 2'b01) ? REMOTE_SAT_MAX : remote_sum[10:0];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= SQ_BOOT;
			boot_q <= '0;
			wait_q <= '0;
			adc_start_o <= 1'b0;
			adc_remote_sel_o <= 1'b0;
			cmp_local_q <= 1'b0;
			cmp_remote_q <= 1'b0;
			// R10 reset to minus 128
			local_temp_q <= TEMP_RESET_HI;
			remote_temp_q <= {TEMP_RESET_HI, 3'h0};
		end else begin
			adc_start_o <= 1'b0;
			cmp_local_q <= 1'b0;
			cmp_remote_q <= 1'b0;
			case (state_q)
				SQ_BOOT: begin
					// let the standby pin settle through the synchroniser
					boot_q <= boot_q + 1'b1;
					if (boot_q == BOOT_CYCLES) begin
						if (standby) begin
							// R12 compare untouched defaults
							cmp_local_q <= 1'b1;
							cmp_remote_q <= 1'b1;
							state_q <= SQ_WAIT;
						end else begin
							// R11 convert first
							state_q <= SQ_START;
						end
					end
				end
				SQ_START: begin
					adc_start_o <= 1'b1;
					state_q <= SQ_BUSY;
				end
				SQ_BUSY: begin
					if (adc_valid_i) begin
						state_q <= avg_last ? SQ_STORE : SQ_START;
					end
				end
				SQ_STORE: begin
					if (avg_done) begin
						if (adc_remote_sel_o) begin
							// R3 eleven-bit remote store
							remote_temp_q <= remote_adj;
							cmp_remote_q <= 1'b1;
							adc_remote_sel_o <= 1'b0;
							wait_q <= '0;
							state_q <= SQ_WAIT;
						end else begin
							// R2 upper eight bits
							local_temp_q <= avg_val[ADC_W-1:ADC_W-8];
							cmp_local_q <= 1'b1;
							// R1 alternate channel
							adc_remote_sel_o <= 1'b1;
							state_q <= SQ_START;
						end
					end
				end
				SQ_WAIT: begin
					if (wait_q < wait_len) begin
						wait_q <= wait_q + 1'b1;
					end else if (!standby) begin
						// R1 free-running restart
						wait_q <= '0;
						state_q <= SQ_START;
					end
				end
				default: begin
					state_q <= SQ_BOOT;
				end
			endcase
		end
	end

	// ****************************************
	// limit comparison and alert
	// ****************************************
	logic [3:0] cond;
	logic [3:0] set_flags;
	logic status_read;
	logic [10:0] remote_high_lim;
	logic [10:0] remote_low_lim;

	assign remote_high_lim = {remote_high_hi_q, remote_high_lo_q[LOW_FRAC_MSB:LOW_FRAC_LSB]};
	assign remote_low_lim = {remote_low_hi_q, remote_low_lo_q[LOW_FRAC_MSB:LOW_FRAC_LSB]};
	// R6 signed limit checks
	assign cond[FLG_LOCAL_HIGH] = $signed(local_temp_q) > $signed(local_high_lim_q);
	assign cond[FLG_LOCAL_LOW] = $signed(local_temp_q) < $signed(local_low_lim_q);
	assign cond[FLG_REMOTE_HIGH] = $signed(remote_temp_q) > $signed(remote_high_lim);
	assign cond[FLG_REMOTE_LOW] = $signed(remote_temp_q) < $signed(remote_low_lim);
	assign set_flags = cond & {cmp_remote_q, cmp_remote_q, cmp_local_q, cmp_local_q};
	assign status_read = req.rd & (req.ptr == PTR_STATUS);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flags_q <= '0;
			alert_oe_o <= 1'b0;
		end else begin
			// R18 read clears healed flags only; R13 and R14 use live limits, set wins
			flags_q <= (flags_q & ~({4{status_read}} & ~cond)) | set_flags;
			// R7 alert follows flags; R19 mask releases it
			alert_oe_o <= (|flags_q) & ~config_q[CFG_MASK_BIT];
		end
	end

endmodule : dual_temp_monitor_core

/* temp_monitor_properties.sv */
`timescale 1ns/1ps
module temp_monitor_properties #(
	parameter int ADC_W = 11,
	parameter int AVG_LOG2 = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic standby_select_n_i,
	input wire logic [ADC_W-1:0] adc_data_i,
	input wire logic adc_valid_i,
	input wire logic adc_start_o,
	input wire logic adc_remote_sel_o,
	input wire logic alert_o,
	input wire logic alert_oe_o
);
	// ****
	// helper counters
	// ****
	localparam logic [5:0] PER_CH = 6'(1 << AVG_LOG2);
	logic sel_q, pend_q, scl_q, low_q, high_q;
	logic [5:0] nst_q, nst_d;
	logic [7:0] idle_q, idle_d;
	logic [8:0] standby_select_n_q, standby_select_n_d;
	logic [4:0] boot_q, nval_q;
	assign nst_d = (adc_remote_sel_o != sel_q) ? 6'(adc_start_o) : nst_q + 6'(adc_start_o);
	assign idle_d = (scl_i != scl_q) ? 8'h00 : idle_q + 8'(idle_q != 8'hff);
	assign standby_select_n_d = standby_select_n_i ? 9'h000 : standby_select_n_q + 9'(standby_select_n_q != 9'h1ff);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{sel_q, pend_q, nst_q, idle_q, standby_select_n_q, boot_q, nval_q} <= '0;
			{scl_q, low_q, high_q} <= 3'b111;
		end else begin
			sel_q <= adc_remote_sel_o;
			pend_q <= adc_start_o | (pend_q & !adc_valid_i);
			scl_q <= scl_i;
			low_q <= low_q & !standby_select_n_i;
			high_q <= high_q & standby_select_n_i;
			nst_q <= nst_d;
			idle_q <= idle_d;
			standby_select_n_q <= standby_select_n_d;
			boot_q <= boot_q + 5'(boot_q != 5'h1f);
			nval_q <= nval_q + 5'(adc_valid_i & !nval_q[4]);
		end
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_start_pulse;
		adc_start_o ##1 !adc_start_o;
	endsequence
	sequence s_ch_switch;
		adc_remote_sel_o != sel_q;
	endsequence
	a_sda_open_drain: assert property (sda_o == 1'b0)
		else $error("data pin value not low");
	a_alert_open_drain: assert property (alert_o == 1'b0)
		else $error("alert pin value not low");
	a_start_one_cycle: assert property (adc_start_o |-> s_start_pulse)
		else $error("sample request longer than one cycle");
	a_wait_for_sample: assert property (adc_start_o |-> !pend_q)
		else $error("sample requested before previous answer");
	a_sixteen_per_channel: assert property (s_ch_switch |-> nst_q == PER_CH)
		else $error("channel switched after wrong sample count");
	a_standby_stops_start: assert property (standby_select_n_q > 9'd400 |-> !adc_start_o)
		else $error("sample requested during standby");
	a_alert_needs_host: assert property ($fell(alert_oe_o) |-> idle_q < 8'd60)
		else $error("alert released without bus traffic");
	a_ack_clock_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("data pulled low while clock high");
	a_standby_boot_alert: assert property (boot_q == 5'd20 && low_q |-> alert_oe_o)
		else $error("no alert after standby power-up");
	// store before compare; a full local average must land first
	a_normal_boot_quiet: assert property (high_q && !nval_q[4] |-> !alert_oe_o)
		else $error("alert before first stored result");
endmodule : temp_monitor_properties

/* smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model
	import temp_monitor_pkg::*;
#(
	parameter logic [6:0] ADDR = SMB_ADDR_DEFAULT
) (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	int nacks = 0;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// ****
	// bit level: low 500 ns, high 300 ns
	// ****
	// long low phase leaves room for the target's synchroniser lag
	task automatic clk_bit(input logic b, output logic s);
		scl_o = 1'b0;
		#150 sda_low_o = !b;
		#350 scl_o = 1'b1;
		#150 s = sda_i;
		#150;
	endtask : clk_bit
	// rx set: host only listens, ack slot is a nack
	task automatic xfer(input logic [7:0] d, input logic rx, output logic [7:0] q);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(1'b1, s);
		if (!rx && s) nacks++;
	endtask : xfer
	task automatic start_cond();
		logic s;
		clk_bit(1'b1, s);
		sda_low_o = 1'b1;
		#300;
	endtask : start_cond
	// clock stays high afterwards: no clock outside frames
	task automatic stop_cond();
		logic s;
		clk_bit(1'b0, s);
		#200 sda_low_o = 1'b0;
		#1300;
	endtask : stop_cond
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] q;
		#37 start_cond();
		xfer({ADDR, 1'b0}, 1'b0, q);
		xfer(ptr, 1'b0, q);
		xfer(d, 1'b0, q);
		stop_cond();
	endtask : wr
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic [7:0] q;
		#37 start_cond();
		xfer({ADDR, 1'b0}, 1'b0, q);
		xfer(ptr, 1'b0, q);
		start_cond();
		xfer({ADDR, 1'b1}, 1'b0, q);
		xfer(8'hff, 1'b1, d);
		stop_cond();
	endtask : rd
endmodule : smbus_host_model

/* tb_dual_temp_monitor_core.sv */
`timescale 1ns/1ps
module tb_dual_temp_monitor_core
	import temp_monitor_pkg::*;
;
	// ****
	// stimulus values
	// ****
	localparam logic [10:0] LOCAL_CODE = 11'h0c8;
	localparam logic [10:0] REMOTE_CODE = 11'h194;
	// minus one degree
	localparam logic [10:0] OFFSET = 11'h7f8;
	localparam logic [10:0] REM_ADJ = REMOTE_CODE + OFFSET;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic standby_select_n_i = 1'b0;
	logic [10:0] adc_data_i = 11'h000;
	logic adc_valid_i = 1'b0;
	logic start_seen = 1'b0;
	logic scl, host_low, sda_o, sda_oe_o, adc_start_o, adc_remote_sel_o, alert_o, alert_oe_o;
	wire logic sda_bus;
	int mismatches = 0;
	int n_checks = 0;
	int nstarts = 0;
	// pull-up on the data line
	assign sda_bus = !(host_low | sda_oe_o);
	initial begin
		forever #50 clk_i = !clk_i;
	end
	dual_temp_monitor_core #(.RATE_UNIT(4)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.standby_select_n_i(standby_select_n_i), .adc_data_i(adc_data_i),
		.adc_valid_i(adc_valid_i), .adc_start_o(adc_start_o),
		.adc_remote_sel_o(adc_remote_sel_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o));
	smbus_host_model host (.sda_i(sda_bus), .scl_o(scl), .sda_low_o(host_low));
	// converter answers two edges after each request
	always @(posedge clk_i) begin
		start_seen <= adc_start_o;
		adc_valid_i <= start_seen;
		adc_data_i <= adc_remote_sel_o ? REMOTE_CODE : LOCAL_CODE;
		if (adc_start_o === 1'b1) nstarts++;
	end
	// ****
	// tasks
	// ****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(ptr, d);
		chk(d, exp);
	endtask : rd_chk
	task automatic alert_is(input logic e);
		@(negedge clk_i);
		chk({7'h00, alert_oe_o}, {7'h00, e});
	endtask : alert_is
	task automatic give_verdict();
		chk(8'(host.nacks), 8'h00);
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic wait_starts(input int n);
		int goal;
		goal = nstarts + n;
		for (int i = 0; i < 20000 && nstarts < goal; i++) @(posedge clk_i);
		if (nstarts < goal) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, nstarts, goal);
			give_verdict();
		end
	endtask : wait_starts
	// ****
	// sequence
	// ****
	initial begin
		int n;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		alert_is(1'b1);
		rd_chk(PTR_LOCAL_TEMP, TEMP_RESET_HI);
		rd_chk(PTR_REMOTE_HI, TEMP_RESET_HI);
		rd_chk(PTR_REMOTE_LO, ZERO_BYTE);
		rd_chk(PTR_OFFSET_HI, ZERO_BYTE);
		rd_chk(PTR_OFFSET_LO, ZERO_BYTE);
		rd_chk(PTR_STATUS, 8'h28);
		rd_chk(8'h20, ZERO_BYTE);
		host.wr(PTR_CONFIG, 8'h80);
		alert_is(1'b0);
		host.wr(PTR_CONFIG, 8'h00);
		alert_is(1'b1);
		host.wr(PTR_LOCAL_LOW_LIM, 8'h80);
		host.wr(PTR_REMOTE_LOW_LIM_HI, 8'h80);
		rd_chk(PTR_STATUS, 8'h28);
		alert_is(1'b0);
		rd_chk(PTR_STATUS, ZERO_BYTE);
		host.wr(PTR_OFFSET_HI, OFFSET[10:3]);
		host.wr(PTR_OFFSET_LO, {OFFSET[2:0], 5'h00});
		rd_chk(PTR_OFFSET_HI, OFFSET[10:3]);
		@(posedge clk_i);
		standby_select_n_i <= 1'b1;
		wait_starts(64);
		rd_chk(PTR_LOCAL_TEMP, LOCAL_CODE[10:3]);
		rd_chk(PTR_REMOTE_HI, REM_ADJ[10:3]);
		rd_chk(PTR_REMOTE_LO, {REM_ADJ[2:0], 5'h00});
		rd_chk(PTR_STATUS, ZERO_BYTE);
		host.wr(PTR_LOCAL_HIGH_LIM, 8'h10);
		host.wr(PTR_REMOTE_HIGH_LIM_HI, 8'h30);
		wait_starts(64);
		alert_is(1'b1);
		host.wr(PTR_LOCAL_HIGH_LIM, HIGH_LIM_RESET);
		host.wr(PTR_REMOTE_HIGH_LIM_HI, HIGH_LIM_RESET);
		rd_chk(PTR_STATUS, 8'h50);
		rd_chk(PTR_STATUS, ZERO_BYTE);
		alert_is(1'b0);
		host.wr(PTR_RATE, 8'h05);
		rd_chk(PTR_RATE, 8'h05);
		host.wr(PTR_REMOTE_HI, 8'h12);
		rd_chk(PTR_REMOTE_HI, REM_ADJ[10:3]);
		host.wr(PTR_CONFIG, 8'h40);
		repeat (400) @(posedge clk_i);
		n = nstarts;
		repeat (400) @(posedge clk_i);
		chk(8'(nstarts - n), 8'h00);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		wait_starts(40);
		alert_is(1'b0);
		rd_chk(PTR_LOCAL_TEMP, LOCAL_CODE[10:3]);
		give_verdict();
	end
endmodule : tb_dual_temp_monitor_core
bind dual_temp_monitor_core temp_monitor_properties #(.ADC_W(ADC_W), .AVG_LOG2(AVG_LOG2)) props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .standby_select_n_i(standby_select_n_i), .adc_data_i(adc_data_i),
	.adc_valid_i(adc_valid_i), .adc_start_o(adc_start_o), .adc_remote_sel_o(adc_remote_sel_o),
	.alert_o(alert_o), .alert_oe_o(alert_oe_o));
